/* design/lpc_pkg.sv */
/*
  Shared constants of the LED port controller: register addresses, configuration bit
  positions, port output codes, reset values and timing figures.
  Assumes a 100 MHz system clock; lpc_top names every constant through the package, the bench writes plain values.
*/
package lpc_pkg;

  // ==========================================================================
  // Addresses
  localparam logic [6:0] ADDR_PORT_FIRST = 7'h00;
  localparam logic [6:0] ADDR_PORT_LAST = 7'h09;
  localparam logic [6:0] ADDR_GROUP_FIRST = 7'h0b;
  localparam logic [6:0] ADDR_GROUP_LAST = 7'h0f;
  localparam logic [6:0] ADDR_INPUT_LOW = 7'h0e;
  localparam logic [6:0] ADDR_INPUT_HIGH = 7'h0f;
  localparam logic [6:0] ADDR_CONFIG = 7'h10;

  // Port masks written by the group addresses 0x0f down to 0x0b, in that order.
  localparam logic [4:0][9:0] GROUP_MASK = {10'h300, 10'h0ff, 10'h3ff, 10'h0f0, 10'h00f};

  // ==========================================================================
  // Configuration bit positions
  localparam int CFG_RUN = 0;
  localparam int CFG_CS_RUN = 1;
  localparam int CFG_RAMP = 2;
  localparam int CFG_FADE = 3;
  localparam int CFG_HOLD = 4;
  localparam int CFG_STAGGER = 5;
  localparam int CFG_OSC = 7;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CFG_RESET_INT = 8'h00;
  localparam logic [7:0] CFG_RESET_EXT = 8'h80;
  localparam logic [7:0] PORT_RESET = 8'hff;

  // ==========================================================================
  // Port output codes
  localparam logic [7:0] CODE_LOW = 8'h00;
  localparam logic [7:0] CODE_INPUT = 8'h01;
  localparam logic [7:0] CODE_SINK = 8'h02;
  localparam logic [7:0] CODE_HIZ = 8'hff;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int OSC_HZ = 32_000;
  localparam int OSC_DIV_CYCLES = CLK_HZ / OSC_HZ;
  localparam int CS_WAKE_US = 3000;
  localparam int CS_WAKE_CYCLES = (CS_WAKE_US * (CLK_HZ / 1_000_000));
  localparam logic [7:0] STAGGER_STEP = 8'h20;
  localparam int FRAME_BITS = 16;

  // ==========================================================================
  // Sequence states
  typedef enum logic [2:0]
  {
    LPC_SHUTDOWN = 3'b000,
    LPC_RUN = 3'b001,
    LPC_HOLDOFF = 3'b010,
    LPC_FADEOFF = 3'b011,
    LPC_RAMPUP = 3'b100
  } lpc_seq_t;

endpackage

/* design/lpc_top.sv */
/*
  Register side of a ten port LED driver and I/O expander: serial register port, configuration
  and sequence state, input port readback, output registers with group writes, and PWM drive.
  Assumes the host frames 16-bit words with chip select low, R/W first, then 7 address bits and
  8 data bits, most significant first, sampled on rising serial clock edges. All pins are
  asynchronous to clk_sys and pass two flip-flops first.
*/
// Overview of operation
// - Run write with ramp-up set during hold-off or fade-off returns to run at once.
// - During fade-off, readback shows fade-off set, hold-off, ramp-up and run clear.
// - During hold-off, readback shows hold-off set, fade-off, ramp-up and run clear.
// - Ramp-up shows ramp-up and run set; run shows only run set, shutdown shows no sequence bits.
// - Bit 5 selects in-phase or staggered PWM and reads back as written.
// - Bit 7 makes shared pin data output with internal oscillator, or clock input.
// - Code 0x01 makes a port high impedance logic input with buffer on.
// - Input register bits show pin level for input ports, else zero.
// - Writes to the input registers 0x0e and 0x0f are group writes to ports 0-7 and 8-9.
// - Address 0x0e reads ports seven down to zero.
// - Address 0x0f reads port nine at bit 1, port eight at bit 0.
// - Ten output registers, one per port, at addresses zero to nine.
// - Addresses 0x0b to 0x0f write one value into a group of output registers.
// - Current ports sink statically or with duty 3/256 to 254/256.
// - One variant powers up on internal oscillator, the other on external clock.
// - Bit 0 selects run or shutdown; bit 1 enables wake by chip-select pulse.
// - A PWM period is 256 PWM clock cycles.
// - With stagger on, successive ports are offset by 32 counts.
// - Code 0x00 drives low, 0x02 sinks statically, 0xff is high impedance.
`timescale 1ns/1ps

module lpc_top
#(
  parameter bit EXT_CLK_DEFAULT = 1'b0,
  parameter int CS_WAKE_CYCLES = lpc_pkg::CS_WAKE_CYCLES,
  parameter int HOLD_PERIODS = 8,
  parameter int FADE_PERIODS = 8,
  parameter int RAMP_PERIODS = 8
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Serial register port
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  // Shared data out / oscillator pin
  input wire logic dout_osc_i,
  output logic dout_osc_o,
  output logic dout_osc_oe,
  // Port pins, open drain
  input wire logic [9:0] io_port_pins_i,
  output logic [9:0] io_port_pins_o,
  output logic [9:0] io_port_pins_oe,
  output logic [9:0] io_port_cc,
  output logic [9:0] general_input_buffer_en
);

  typedef struct packed
  {
    logic [1:0] cs_s;
    logic [1:0] sclk_s;
    logic [1:0] din_s;
    logic [1:0] osc_s;
    logic [9:0] pin_s1;
    logic [9:0] pin_s2;
    logic sclk_prev;
    logic cs_prev;
    logic osc_prev;
    logic [4:0] bit_cnt;
    logic [15:0] rx;
    logic [7:0] tx;
    logic dout;
    logic dout_oe;
    logic [9:0][7:0] port;
    logic cfg_osc;
    logic cfg_stagger;
    logic cfg_ramp;
    logic cfg_cs_run;
    lpc_pkg::lpc_seq_t seq;
    logic [15:0] seq_cnt;
    logic [11:0] osc_div;
    logic [7:0] pwm_cnt;
    logic [19:0] cs_low_cnt;
    logic [9:0] pin_o;
    logic [9:0] pin_oe;
    logic [9:0] cc;
    logic [9:0] gib;
  } lpc_state_t;

  lpc_state_t s_q;
  lpc_state_t s_d;

  localparam logic [7:0] CFG_RESET = EXT_CLK_DEFAULT ? lpc_pkg::CFG_RESET_EXT : lpc_pkg::CFG_RESET_INT;

  // ==========================================================================
  // Combinational next state
  always_comb
  begin
    logic sclk_rise;
    logic sclk_fall;
    logic frame_start;
    logic frame_end;
    logic pwm_tick;
    logic period_end;
    logic active;
    logic [6:0] addr;
    logic [7:0] data;
    logic [7:0] rd;
    logic [7:0] phase;
    logic [15:0] rx_next;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    frame_start = 1'b0;
    frame_end = 1'b0;
    pwm_tick = 1'b0;
    period_end = 1'b0;
    active = 1'b0;
    addr = 7'h00;
    data = 8'h00;
    rd = 8'h00;
    phase = 8'h00;
    rx_next = 16'h0000;
    s_d = s_q;

    // Pins cross into clk_sys through two flip-flops; only the second stage is read.
    s_d.cs_s = {s_q.cs_s[0], cs_n};
    s_d.sclk_s = {s_q.sclk_s[0], sclk};
    s_d.din_s = {s_q.din_s[0], din};
    s_d.osc_s = {s_q.osc_s[0], dout_osc_i};
    s_d.pin_s1 = io_port_pins_i;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.sclk_prev = s_q.sclk_s[1];
    s_d.cs_prev = s_q.cs_s[1];
    s_d.osc_prev = s_q.osc_s[1];
    sclk_rise = s_q.sclk_s[1] && !s_q.sclk_prev && !s_q.cs_s[1];
    sclk_fall = !s_q.sclk_s[1] && s_q.sclk_prev && !s_q.cs_s[1];
    frame_start = !s_q.cs_s[1] && s_q.cs_prev;
    frame_end = s_q.cs_s[1] && !s_q.cs_prev;

    // ========================================================================
    // PWM clock select
    // clock source select
    if (s_q.cfg_osc)
    begin
      s_d.osc_div = 12'h000;
      pwm_tick = s_q.osc_s[1] && !s_q.osc_prev;
    end
    else if (s_q.osc_div == 12'(lpc_pkg::OSC_DIV_CYCLES - 1))
    begin
      s_d.osc_div = 12'h000;
      pwm_tick = 1'b1;
    end
    else
    begin
      s_d.osc_div = s_q.osc_div + 12'h001;
    end
    if (pwm_tick)
    begin
      s_d.pwm_cnt = s_q.pwm_cnt + 8'h01;
      period_end = (s_q.pwm_cnt == 8'hff);
    end

    // ========================================================================
    // Read data assembled from live state
    // After eight bits the R/W flag sits at bit 7 and the address in the bits below it.
    addr = s_q.rx[6:0];
    if (addr <= lpc_pkg::ADDR_PORT_LAST)
    begin
      rd = s_q.port[4'(addr)];
    end
    else if (addr == lpc_pkg::ADDR_INPUT_LOW)
    begin
      for (int i = 0; i < 8; i++)
      begin
        rd[i] = (s_q.port[i] == lpc_pkg::CODE_INPUT) && s_q.pin_s2[i];
      end
    end
    else if (addr == lpc_pkg::ADDR_INPUT_HIGH)
    begin
      for (int i = 0; i < 2; i++)
      begin
        rd[i] = (s_q.port[i + 8] == lpc_pkg::CODE_INPUT) && s_q.pin_s2[i + 8];
      end
    end
    else if (addr == lpc_pkg::ADDR_CONFIG)
    begin
      rd[lpc_pkg::CFG_OSC] = s_q.cfg_osc;
      rd[lpc_pkg::CFG_STAGGER] = s_q.cfg_stagger;
      rd[lpc_pkg::CFG_HOLD] = (s_q.seq == lpc_pkg::LPC_HOLDOFF);
      rd[lpc_pkg::CFG_FADE] = (s_q.seq == lpc_pkg::LPC_FADEOFF);
      rd[lpc_pkg::CFG_RAMP] = (s_q.seq == lpc_pkg::LPC_RAMPUP);
      rd[lpc_pkg::CFG_CS_RUN] = s_q.cfg_cs_run;
      rd[lpc_pkg::CFG_RUN] = (s_q.seq == lpc_pkg::LPC_RUN) || (s_q.seq == lpc_pkg::LPC_RAMPUP);
    end

    // ========================================================================
    // Serial frame
    if (frame_start)
    begin
      s_d.bit_cnt = 5'd0;
    end
    if (sclk_rise && s_q.bit_cnt != 5'(lpc_pkg::FRAME_BITS))
    begin
      rx_next = {s_q.rx[14:0], s_q.din_s[1]};
      s_d.rx = rx_next;
      s_d.bit_cnt = s_q.bit_cnt + 5'd1;
    end
    // Read data is latched when the address is complete, so it reflects the state at that moment.
    if (sclk_fall && s_q.bit_cnt == 5'd8)
    begin
      s_d.dout = rd[7];
      s_d.tx = {rd[6:0], 1'b0};
    end
    else if (sclk_fall && s_q.bit_cnt > 5'd8)
    begin
      s_d.dout = s_q.tx[7];
      s_d.tx = {s_q.tx[6:0], 1'b0};
    end
    s_d.dout_oe = !s_q.cfg_osc && !s_q.cs_s[1];

    // ========================================================================
    // Sequence timing
    if (period_end && s_q.seq_cnt != 16'h0000)
    begin
      s_d.seq_cnt = s_q.seq_cnt - 16'h0001;
    end
    unique case (s_q.seq)
      lpc_pkg::LPC_HOLDOFF:
      begin
        if (s_q.seq_cnt == 16'h0000)
        begin
          s_d.seq = lpc_pkg::LPC_FADEOFF;
          s_d.seq_cnt = 16'(FADE_PERIODS);
        end
      end
      lpc_pkg::LPC_FADEOFF:
      begin
        if (s_q.seq_cnt == 16'h0000)
        begin
          s_d.seq = lpc_pkg::LPC_SHUTDOWN;
        end
      end
      lpc_pkg::LPC_RAMPUP:
      begin
        if (s_q.seq_cnt == 16'h0000)
        begin
          s_d.seq = lpc_pkg::LPC_RUN;
        end
      end
      lpc_pkg::LPC_SHUTDOWN:
      begin
        if (s_q.cfg_cs_run && !s_q.cs_s[1] && s_q.cs_low_cnt == 20'(CS_WAKE_CYCLES - 1))
        begin
          s_d.seq = s_q.cfg_ramp ? lpc_pkg::LPC_RAMPUP : lpc_pkg::LPC_RUN;
          s_d.seq_cnt = 16'(RAMP_PERIODS);
        end
      end
      lpc_pkg::LPC_RUN:
      begin
      end
    endcase
    if (s_q.cs_s[1])
    begin
      s_d.cs_low_cnt = 20'h00000;
    end
    else if (s_q.cs_low_cnt != 20'(CS_WAKE_CYCLES))
    begin
      s_d.cs_low_cnt = s_q.cs_low_cnt + 20'h00001;
    end

    // ========================================================================
    // Write commit at the end of a full frame
    addr = s_q.rx[14:8];
    data = s_q.rx[7:0];
    if (frame_end && s_q.bit_cnt == 5'(lpc_pkg::FRAME_BITS) && !s_q.rx[15])
    begin
      if (addr <= lpc_pkg::ADDR_PORT_LAST)
      begin
        s_d.port[4'(addr)] = data;
      end
      else if (addr >= lpc_pkg::ADDR_GROUP_FIRST && addr <= lpc_pkg::ADDR_GROUP_LAST)
      begin
        for (int i = 0; i < 10; i++)
        begin
          if (lpc_pkg::GROUP_MASK[3'(addr - lpc_pkg::ADDR_GROUP_FIRST)][i])
          begin
            s_d.port[i] = data;
          end
        end
      end
      else if (addr == lpc_pkg::ADDR_CONFIG)
      begin
        s_d.cfg_osc = data[lpc_pkg::CFG_OSC];
        s_d.cfg_stagger = data[lpc_pkg::CFG_STAGGER];
        s_d.cfg_ramp = data[lpc_pkg::CFG_RAMP];
        s_d.cfg_cs_run = data[lpc_pkg::CFG_CS_RUN];
        if (!data[lpc_pkg::CFG_RUN])
        begin
          if (s_q.seq == lpc_pkg::LPC_RUN || s_q.seq == lpc_pkg::LPC_RAMPUP)
          begin
            s_d.seq = lpc_pkg::LPC_HOLDOFF;
            s_d.seq_cnt = 16'(HOLD_PERIODS);
          end
        end
        else if (s_q.seq == lpc_pkg::LPC_SHUTDOWN)
        begin
          s_d.seq = data[lpc_pkg::CFG_RAMP] ? lpc_pkg::LPC_RAMPUP : lpc_pkg::LPC_RUN;
          s_d.seq_cnt = 16'(RAMP_PERIODS);
        end
        else if (data[lpc_pkg::CFG_RAMP]
                 && (s_q.seq == lpc_pkg::LPC_HOLDOFF || s_q.seq == lpc_pkg::LPC_FADEOFF))
        begin
          s_d.seq = lpc_pkg::LPC_RUN;
          s_d.seq_cnt = 16'h0000;
        end
      end
    end

    // ========================================================================
    // Port drive
    active = (s_q.seq != lpc_pkg::LPC_SHUTDOWN);
    for (int i = 0; i < 10; i++)
    begin
      phase = s_q.pwm_cnt - (s_q.cfg_stagger ? 8'(i * lpc_pkg::STAGGER_STEP) : 8'h00);
      s_d.pin_o[i] = 1'b0;
      s_d.cc[i] = 1'b0;
      s_d.gib[i] = 1'b0;
      s_d.pin_oe[i] = 1'b0;
      if (s_q.port[i] == lpc_pkg::CODE_LOW)
      begin
        s_d.pin_oe[i] = 1'b1;
        s_d.gib[i] = 1'b1;
      end
      else if (s_q.port[i] == lpc_pkg::CODE_INPUT)
      begin
        s_d.gib[i] = 1'b1;
      end
      else if (s_q.port[i] == lpc_pkg::CODE_SINK)
      begin
        s_d.pin_oe[i] = active;
        s_d.cc[i] = active;
      end
      else if (s_q.port[i] != lpc_pkg::CODE_HIZ)
      begin
        s_d.pin_oe[i] = active && (phase < s_q.port[i]);
        s_d.cc[i] = s_d.pin_oe[i];
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.cs_s <= 2'b11;
      s_q.cs_prev <= 1'b1;
      s_q.bit_cnt <= 5'(lpc_pkg::FRAME_BITS);
      s_q.port <= {10{lpc_pkg::PORT_RESET}};
      s_q.cfg_osc <= CFG_RESET[lpc_pkg::CFG_OSC];
      s_q.seq <= lpc_pkg::LPC_SHUTDOWN;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign dout_osc_o = s_q.dout;
  assign dout_osc_oe = s_q.dout_oe;
  assign io_port_pins_o = s_q.pin_o;
  assign io_port_pins_oe = s_q.pin_oe;
  assign io_port_cc = s_q.cc;
  assign general_input_buffer_en = s_q.gib;

endmodule

/* verification/lpc_assertions.sv */
/*
  Checker of the LED port controller pins.
  Assumes it is bound to lpc_top and sees only that module's ports.
*/
`timescale 1ns/1ps

module lpc_checker
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Watched pins
  input wire logic cs_n,
  input wire logic dout_osc_oe,
  input wire logic [9:0] io_port_pins_o,
  input wire logic [9:0] io_port_pins_oe,
  input wire logic [9:0] io_port_cc,
  input wire logic [9:0] general_input_buffer_en
);
  // ====================
  // Port drive
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_pins_open_drain: assert property (io_port_pins_o == 10'h000)
    else $error("port pin driven high");
  a_buffer_cc_excl: assert property ((general_input_buffer_en & io_port_cc) == 10'h000)
    else $error("input buffer and current sink both on");
  // Reset is checked while it is asserted, so the default disable is overridden.
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> (io_port_pins_oe == 10'h000
    && io_port_cc == 10'h000 && general_input_buffer_en == 10'h000 && !dout_osc_oe))
    else $error("outputs active during reset");
  a_release_idle: assert property (disable iff (1'b0) rst ##1 !rst |->
    (io_port_pins_oe == 10'h000 && general_input_buffer_en == 10'h000) [*3])
    else $error("ports active right after reset");
  a_buffer_after_frame: assert property ($changed(general_input_buffer_en) |->
    $past(cs_n, 2) || $past(rst))
    else $error("input buffer changed inside a frame");
  a_buffer_in_frame: assert property (!cs_n [*4] |-> $stable(general_input_buffer_en))
    else $error("input buffer changed with chip select low");

  // ====================
  // Shared data pin
  a_dout_idle: assert property (cs_n [*5] |-> !dout_osc_oe)
    else $error("data out driven while deselected");
  a_dout_rise: assert property ($rose(dout_osc_oe) |-> !$past(cs_n, 2))
    else $error("data out enabled without chip select");
  a_dout_fall: assert property ($fell(dout_osc_oe) |-> $past(cs_n, 2) || $past(rst))
    else $error("data out released inside a frame");

  c_dout_on: cover property ($rose(dout_osc_oe));
  c_buffer_write: cover property ($changed(general_input_buffer_en));
  c_sink_on: cover property ($rose(|io_port_cc));
endmodule

bind lpc_top lpc_checker lpc_checker_inst (.clk_sys, .rst, .cs_n, .dout_osc_oe, .io_port_pins_o,
  .io_port_pins_oe, .io_port_cc, .general_input_buffer_en);

/* verification/lpc_host.sv */
/*
  Host model of the serial register port: frames of 16 bits, most significant first.
  Assumes the shared pin level is resolved outside and handed in as dout.
*/
`timescale 1ns/1ps

module lpc_host
(
  // Serial port toward the device
  output logic cs_n,
  output logic sclk,
  output logic din,
  // Shared pin level
  input wire logic dout
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end

  // ====================
  // Frame transfer
  // frame carries configuration
  task automatic xfer(input logic [15:0] w, input realtime half, output logic [7:0] rd);
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      din = w[i];
      #half;
      if (i < 8)
        rd[i] = dout;
      sclk = 1'b1;
      #half;
      sclk = 1'b0;
    end
    #half;
    cs_n = 1'b1;
    // A released line with no pull must not keep looking valid.
    din = ~din;
    #(2 * half);
  endtask
endmodule

/* verification/testbench.sv */
/*
  Self-checking bench of the LED port controller: register frames, group writes,
  input readback and the shutdown sequence status.
  Assumes the host model drives the serial port and the bench makes the external PWM clock.
*/
`timescale 1ns/1ps

module testbench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic osc_drv = 1'b0;
  logic [9:0] pins_in = 10'h2a5;
  logic [9:0] m;
  logic [9:0] masks [5] = '{10'h00f, 10'h0f0, 10'h3ff, 10'h0ff, 10'h300};
  wire logic cs_n, sclk, din, dout_osc_o, dout_osc_oe, dout_osc_i;
  wire logic [9:0] pins_o, pins_oe, cc, gib;
  int failures = 0;
  int checks_done = 0;

  assign dout_osc_i = dout_osc_oe ? dout_osc_o : osc_drv;

  always #5 clk_sys = ~clk_sys;

  lpc_top #(.EXT_CLK_DEFAULT(1'b0), .CS_WAKE_CYCLES(20), .HOLD_PERIODS(1), .FADE_PERIODS(1),
    .RAMP_PERIODS(1)) lpc_top_inst (.clk_sys, .rst, .cs_n, .sclk, .din, .dout_osc_i, .dout_osc_o,
    .dout_osc_oe, .io_port_pins_i(pins_in), .io_port_pins_o(pins_o), .io_port_pins_oe(pins_oe),
    .io_port_cc(cc), .general_input_buffer_en(gib));

  lpc_host lpc_host_inst (.cs_n, .sclk, .din, .dout(dout_osc_i));

  // ====================
  // Tasks
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    lpc_host_inst.xfer({1'b0, a, d}, 62.5, r);
    @(posedge clk_sys);
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] r;
    lpc_host_inst.xfer({1'b1, a, 8'h00}, 62.5, r);
    chk($sformatf("reg %h", a), {2'b00, r}, {2'b00, exp});
  endtask

  // Exactly 256 edges always cross one PWM period boundary, whatever the count was.
  task automatic ticks(input int n);
    repeat (2 * n)
    begin
      repeat (3) @(posedge clk_sys);
      osc_drv <= ~osc_drv;
    end
    // The last edge needs two synchroniser stages, the counter and the port flop to settle.
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ====================
  // Tests
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("oe", pins_oe, 10'h000);
    rdchk(7'h10, 8'h00);
    wr(7'h0d, 8'h00);
    chk("oe", pins_oe, 10'h3ff);
    chk("gib", gib, 10'h3ff);
    chk("cc", cc, 10'h000);
    rdchk(7'h0e, 8'h00);
    wr(7'h0d, 8'h02);
    chk("oe", pins_oe, 10'h000);
    wr(7'h0d, 8'hff);
    m = 10'h000;
    for (int i = 0; i < 10; i++)
    begin
      wr(i[6:0], 8'h01);
      m = m | (10'h001 << i);
      chk("gib", gib, m);
    end
    for (int g = 0; g < 5; g++)
    begin
      wr(7'h0d, 8'hff);
      wr(7'h0b + g[6:0], 8'h01);
      chk("gib", gib, masks[g]);
      chk("oe", pins_oe, 10'h000);
      rdchk(7'h0e, pins_in[7:0] & masks[g][7:0]);
      rdchk(7'h0f, {6'h00, pins_in[9:8] & masks[g][9:8]});
    end
    wr(7'h10, 8'h20);
    rdchk(7'h10, 8'h20);
    wr(7'h10, 8'h21);
    rdchk(7'h10, 8'h21);
    wr(7'h10, 8'h20);
    rdchk(7'h10, 8'h30);
    wr(7'h10, 8'h25);
    rdchk(7'h10, 8'h21);
    wr(7'h10, 8'h20);
    rdchk(7'h10, 8'h30);
    wr(7'h10, 8'ha0);
    rdchk(7'h10, 8'h00);
    ticks(256);
    wr(7'h10, 8'h20);
    rdchk(7'h10, 8'h28);
    wr(7'h10, 8'ha0);
    ticks(256);
    wr(7'h10, 8'h20);
    rdchk(7'h10, 8'h20);
    wr(7'h10, 8'h25);
    rdchk(7'h10, 8'h25);
    wr(7'h0d, 8'h02);
    chk("oe", pins_oe, 10'h3ff);
    chk("cc", cc, 10'h3ff);
    // Stagger stays set, so the phase of the running PWM is never changed here.
    wr(7'h10, 8'ha5);
    wr(7'h0d, 8'h10);
    for (int k = 0; k < 16 && pins_oe[0] === 1'b1; k++)
      ticks(1);
    for (int k = 0; k < 256 && pins_oe[0] !== 1'b1; k++)
      ticks(1);
    chk("oe", pins_oe, 10'h101);
    chk("cc", cc, 10'h101);
    ticks(32);
    chk("oe", pins_oe, 10'h202);
    ticks(16);
    chk("oe", pins_oe, 10'h000);
    ticks(208);
    chk("oe", pins_oe, 10'h101);
    wr(7'h10, 8'ha0);
    ticks(256);
    ticks(256);
    chk("oe", pins_oe, 10'h000);
    wr(7'h10, 8'h22);
    rdchk(7'h10, 8'h23);
    results();
  end

  initial
  begin
    #600000;
    failures++;
    results();
  end
endmodule
